// >>> int_expansion_consts.vh
/*
 * Constants for the two-level interrupt path: register addresses, field
 * widths, source-to-level map, vectors, timing counts and FSM codes.
 * Assumes the includer uses them with the widths given here.
 */
`ifndef INT_EXPANSION_CONSTS_VH
`define INT_EXPANSION_CONSTS_VH

// ==========================================================
// sizes
`define NUM_SRC 31
`define NUM_LVL 6
`define SRC_IDX_W 5
`define LVL_W 3
`define DATA_W 16

// ==========================================================
// data-space register addresses
`define ADDR_LEVEL_MASK 16'h0004
`define ADDR_LEVEL_FLAGS 16'h0006
`define ADDR_VECTOR 16'h701E

// ==========================================================
// field layout and reset values
`define LEVEL_FIELD_MSB 5
`define LEVEL_PAD 10'h000
`define LEVEL_FLAGS_RST 6'h00
`define VECTOR_RST 16'h0000

// ==========================================================
// last source index of levels one to five; the rest are level six
`define LVL1_LAST 8
`define LVL2_LAST 15
`define LVL3_LAST 19
`define LVL4_LAST 22
`define LVL5_LAST 27

// ==========================================================
// vectors: level n fetches at 2n in program space
`define LVL_VEC_SHIFT 1
`define LVL_MIN 3'h1
`define LVL_MAX 3'h6
`define LVL_NONE 3'h0
`define PAB_IDLE 16'h0000
`define SRC_VEC_BASE 16'h0001
`define PHANTOM_VEC 16'h0000

// ==========================================================
// timing in clock cycles
`define REQ_PULSE_CYC 2'h2
`define CORE_LAT_CYC 3'h4
`define CORE_LAT_START 3'h1

// ==========================================================
// core state codes, one-hot
`define ST_IDLE 3'h1
`define ST_WAIT 3'h2
`define ST_ACK 3'h4

`endif

// >>> level_req_pulse.v
/*
 * One CPU level request generator: an active-low pulse per new request,
 * with an outstanding flag held until the level is acknowledged.
 * Assumes reqAny and ackHit come from logic on the same clock.
 */
`timescale 1ns/1ns
`include "int_expansion_consts.vh"

module level_req_pulse (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // request side
   input wire reqAny,
   input wire ackHit,
   // outputs
   output reg reqLow_b,
   output reg outstanding_r
);

   // ==========================================================
   // pulse timer
   reg [1:0] cnt_r;
   wire start;

   // a new pulse only when nothing earlier on this level is unanswered
   assign start = reqLow_b && reqAny && !outstanding_r;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reqLow_b <= 1'b1;
         cnt_r <= 2'h0;
      end else if (!reqLow_b) begin
         if (cnt_r == (`REQ_PULSE_CYC - 2'h1)) begin
            reqLow_b <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 2'h1;
         end
      end else if (start) begin
         reqLow_b <= 1'b0;
         cnt_r <= 2'h0;
      end
   end

   // ==========================================================
   // outstanding flag; ack frees it so a still-active source re-pulses
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         outstanding_r <= 1'b0;
      end else if (ackHit) begin
         outstanding_r <= 1'b0;
      end else if (start) begin
         outstanding_r <= 1'b1;
      end
   end

endmodule // level_req_pulse

// >>> int_expansion.v
/*
 * Two-level maskable interrupt path: peripheral event flags and requests,
 * the expansion controller with its level pulses and vector register, and
 * the core-level flag/mask registers with the take-and-acknowledge logic.
 * Assumes peripherals, the data bus and core control are on clk.
 */
// Notes on behaviour
// - flag and enable both set raise request
// - disabled event flag stays set until cleared
// - level pulse only if none outstanding there
// - level request is low for two cycles
// - level request sets its level flag
// - take unmasked pending level, set global mask
// - acknowledge drives level vector on address
// - decode address, acknowledge that level's request
// - load vector register, phantom when none
// - at least four cycles to vector fetch
// - during stall, higher level may take over
// - flag register at 0006h, six bits
// - write one clears flag, zero ignored
// - acknowledge and reset clear level flags
// - acknowledge leaves peripheral event flag set
// - software interrupt entry keeps its flag
// - mask register at 0004h, one unmasks
// - masked level acknowledged only by software entry
// - still active after acknowledge pulses again
// - acknowledge clears highest priority request only
// - mask bits keep value across reset
`timescale 1ns/1ns
`include "int_expansion_consts.vh"

module int_expansion (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // peripheral events
   input wire [`NUM_SRC-1:0] eventPulse,
   input wire [`NUM_SRC-1:0] eventClear,
   input wire [`NUM_SRC-1:0] eventEnable,
   // data-space register access
   input wire [`DATA_W-1:0] dataAddr,
   input wire [`DATA_W-1:0] dataWrData,
   input wire dataWr,
   input wire dataRd,
   // core control
   input wire interruptible,
   input wire globalMaskClear,
   input wire swIntReq,
   input wire [`LVL_W-1:0] swIntLevel,
   // peripheral status
   output reg [`NUM_SRC-1:0] eventFlag_r,
   output reg [`NUM_SRC-1:0] peripheralRequest_r,
   output reg [`NUM_SRC-1:0] peripheralAck_r,
   // core status
   output wire [`NUM_LVL-1:0] cpuLevelRequest_b,
   output reg globalMask_r,
   output reg intAck_r,
   output reg [`DATA_W-1:0] programAddr_r,
   output reg [`DATA_W-1:0] vector_r,
   output reg [`DATA_W-1:0] rdData_r
);

   // ==========================================================
   // declarations
   localparam ST_IDLE = `ST_IDLE;
   localparam ST_WAIT = `ST_WAIT;
   localparam ST_ACK = `ST_ACK;

   reg [`NUM_SRC-1:0] gatePrev_r;
   reg [`NUM_LVL-1:0] reqPrev_r;
   reg [`NUM_LVL-1:0] levelFlags_r;
   reg [`NUM_LVL-1:0] levelMask_r;
   reg [2:0] state_r;
   reg [2:0] latCnt_r;
   reg [`LVL_W-1:0] takenLvl_r;
   reg takenSw_r;

   wire [`NUM_SRC-1:0] eventGate;
   wire [`NUM_SRC-1:0] gateRise;
   wire [`NUM_LVL-1:0] reqFall;
   wire [`NUM_LVL-1:0] outstanding;
   wire [`NUM_LVL-1:0] wrClear;
   wire [`NUM_LVL-1:0] candidate;
   wire [`LVL_W-1:0] decLvl;
   wire decValid;
   wire swValid;

   reg [`NUM_LVL-1:0] levelAny;
   reg [`NUM_LVL-1:0] ackHit;
   reg [`NUM_LVL-1:0] ackClear;
   reg [`NUM_SRC-1:0] ackOneHot;
   reg [`SRC_IDX_W-1:0] ackIdx;
   reg ackFound;
   reg [`LVL_W-1:0] pickLvl;
   reg pickAny;
   reg [`NUM_SRC-1:0] eventFlag_nxt;
   reg [`NUM_SRC-1:0] peripheralRequest_nxt;
   reg [`NUM_LVL-1:0] levelFlags_nxt;
   reg [`DATA_W-1:0] rdData_nxt;
   integer i;

   // ==========================================================
   // source to level map, fixed by the expansion controller
   function [`LVL_W-1:0] levelOf;
      input integer idx;
      begin
         if (idx <= `LVL1_LAST) begin
            levelOf = 3'h1;
         end else if (idx <= `LVL2_LAST) begin
            levelOf = 3'h2;
         end else if (idx <= `LVL3_LAST) begin
            levelOf = 3'h3;
         end else if (idx <= `LVL4_LAST) begin
            levelOf = 3'h4;
         end else if (idx <= `LVL5_LAST) begin
            levelOf = 3'h5;
         end else begin
            levelOf = 3'h6;
         end
      end
   endfunction

   // ==========================================================
   // peripheral event flags and requests
   assign eventGate = eventFlag_r & eventEnable;
   // edge so an acknowledged request is not revived by a still-set flag
   assign gateRise = eventGate & ~gatePrev_r;

   always @* begin
      // set beats a software clear in the same cycle
      eventFlag_nxt = (eventFlag_r & ~eventClear) | eventPulse;
      // acknowledge drops only the request; the flag itself stays
      peripheralRequest_nxt = ((peripheralRequest_r & ~peripheralAck_r) |
                               gateRise) & eventGate;
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         eventFlag_r <= {`NUM_SRC{1'b0}};
         peripheralRequest_r <= {`NUM_SRC{1'b0}};
         gatePrev_r <= {`NUM_SRC{1'b0}};
      end else begin
         eventFlag_r <= eventFlag_nxt;
         peripheralRequest_r <= peripheralRequest_nxt;
         gatePrev_r <= eventGate;
      end
   end

   // ==========================================================
   // per-level request collection
   always @* begin
      levelAny = {`NUM_LVL{1'b0}};
      for (i = 0; i < `NUM_SRC; i = i + 1) begin
         if (peripheralRequest_r[i] && !peripheralAck_r[i]) begin
            levelAny[levelOf(i) - `LVL_MIN] = 1'b1;
         end
      end
   end

   // ==========================================================
   // acknowledge decode from the program address bus
   assign decLvl = programAddr_r[`LVL_W:`LVL_VEC_SHIFT];
   assign decValid = intAck_r &&
                     (programAddr_r[`DATA_W-1:`LVL_W+1] == 12'h000) &&
                     !programAddr_r[0] &&
                     (decLvl >= `LVL_MIN) && (decLvl <= `LVL_MAX);

   always @* begin
      ackHit = {`NUM_LVL{1'b0}};
      ackOneHot = {`NUM_SRC{1'b0}};
      ackIdx = {`SRC_IDX_W{1'b0}};
      ackFound = 1'b0;
      for (i = 0; i < `NUM_LVL; i = i + 1) begin
         if (decValid && (decLvl == i + 1)) begin
            ackHit[i] = 1'b1;
         end
      end
      // descending scan: the lowest index on the level wins
      for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
         if (decValid && peripheralRequest_r[i] && levelOf(i) == decLvl) begin
            ackOneHot = {`NUM_SRC{1'b0}};
            ackOneHot[i] = 1'b1;
            ackIdx = i[`SRC_IDX_W-1:0];
            ackFound = 1'b1;
         end
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         peripheralAck_r <= {`NUM_SRC{1'b0}};
         vector_r <= `VECTOR_RST;
      end else begin
         peripheralAck_r <= ackOneHot;
         if (decValid) begin
            // a later acknowledge overwrites; software must read first
            if (ackFound) begin
               vector_r <= `SRC_VEC_BASE + {11'h000, ackIdx};
            end else begin
               vector_r <= `PHANTOM_VEC;
            end
         end
      end
   end

   // ==========================================================
   // level request pulse generators
   genvar g;
   generate
      for (g = 0; g < `NUM_LVL; g = g + 1) begin : lvl
         level_req_pulse pulse (
            .clk(clk),
            .rst_b(rst_b),
            .reqAny(levelAny[g]),
            .ackHit(ackHit[g]),
            .reqLow_b(cpuLevelRequest_b[g]),
            .outstanding_r(outstanding[g])
         );
      end
   endgenerate

   // ==========================================================
   // level flag register, write one to clear
   assign reqFall = reqPrev_r & ~cpuLevelRequest_b;
   assign wrClear = (dataWr && dataAddr == `ADDR_LEVEL_FLAGS) ?
                    dataWrData[`LEVEL_FIELD_MSB:0] :
                    {`NUM_LVL{1'b0}};

   always @* begin
      ackClear = {`NUM_LVL{1'b0}};
      for (i = 0; i < `NUM_LVL; i = i + 1) begin
         // software-interrupt entry leaves its flag for software
         if (intAck_r && !takenSw_r && takenLvl_r == i + 1) begin
            ackClear[i] = 1'b1;
         end
      end
      // arriving request wins over either clear
      levelFlags_nxt = (levelFlags_r & ~wrClear & ~ackClear) | reqFall;
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         levelFlags_r <= `LEVEL_FLAGS_RST;
         reqPrev_r <= {`NUM_LVL{1'b1}};
      end else begin
         levelFlags_r <= levelFlags_nxt;
         reqPrev_r <= cpuLevelRequest_b;
      end
   end

   // ==========================================================
   // level mask register; deliberately outside the reset
   always @(posedge clk) begin
      if (dataWr && dataAddr == `ADDR_LEVEL_MASK) begin
         levelMask_r <= dataWrData[`LEVEL_FIELD_MSB:0];
      end
   end

   // ==========================================================
   // level selection: pending and unmasked, lowest number first
   assign candidate = levelFlags_r & levelMask_r;

   always @* begin
      pickLvl = `LVL_NONE;
      pickAny = 1'b0;
      for (i = `NUM_LVL - 1; i >= 0; i = i - 1) begin
         if (candidate[i]) begin
            pickLvl = i[`LVL_W-1:0] + 3'h1;
            pickAny = 1'b1;
         end
      end
   end

   assign swValid = swIntReq && (swIntLevel >= `LVL_MIN) &&
                    (swIntLevel <= `LVL_MAX);

   // ==========================================================
   // core take and acknowledge sequence
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         latCnt_r <= 3'h0;
         takenLvl_r <= `LVL_NONE;
         takenSw_r <= 1'b0;
         intAck_r <= 1'b0;
         programAddr_r <= `PAB_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (swValid) begin
                  takenLvl_r <= swIntLevel;
                  takenSw_r <= 1'b1;
                  latCnt_r <= `CORE_LAT_START;
                  state_r <= ST_WAIT;
               end else if (pickAny && !globalMask_r && interruptible) begin
                  // selection freezes here; later arrivals wait
                  takenLvl_r <= pickLvl;
                  takenSw_r <= 1'b0;
                  latCnt_r <= `CORE_LAT_START;
                  state_r <= ST_WAIT;
               end
               // while not interruptible, re-picked each cycle
            end
            ST_WAIT: begin
               if (latCnt_r == `CORE_LAT_CYC) begin
                  intAck_r <= 1'b1;
                  programAddr_r <= {13'h0000, takenLvl_r} <<
                                   `LVL_VEC_SHIFT;
                  state_r <= ST_ACK;
               end else begin
                  latCnt_r <= latCnt_r + 3'h1;
               end
            end
            ST_ACK: begin
               intAck_r <= 1'b0;
               programAddr_r <= `PAB_IDLE;
               state_r <= ST_IDLE;
            end
            default: begin
               intAck_r <= 1'b0;
               programAddr_r <= `PAB_IDLE;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // global mask: set on take, cleared by the handler
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         globalMask_r <= 1'b1;
      end else if (state_r == ST_IDLE &&
                   (swValid || (pickAny && !globalMask_r &&
                    interruptible))) begin
         globalMask_r <= 1'b1;
      end else if (globalMaskClear) begin
         globalMask_r <= 1'b0;
      end
   end

   // ==========================================================
   // register read port, answers one cycle after the strobe
   always @* begin
      rdData_nxt = {`DATA_W{1'b0}};
      if (dataRd) begin
         case (dataAddr)
            `ADDR_LEVEL_MASK: begin
               rdData_nxt = {`LEVEL_PAD, levelMask_r};
            end
            `ADDR_LEVEL_FLAGS: begin
               rdData_nxt = {`LEVEL_PAD, levelFlags_r};
            end
            `ADDR_VECTOR: begin
               rdData_nxt = vector_r;
            end
            default: begin
               rdData_nxt = {`DATA_W{1'b0}};
            end
         endcase
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData_r <= {`DATA_W{1'b0}};
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

endmodule // int_expansion

// >>> event_source.sv
/*
 * partner model: peripheral event sources, one-cycle event pulses.
 * assumes the bench raises fire for one clk cycle per event.
 */
`timescale 1ns/1ns
`include "int_expansion_consts.vh"

module event_source (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // command from the bench
   input wire logic [`NUM_SRC-1:0] fire,
   // events to the block
   output logic [`NUM_SRC-1:0] eventPulse
);
   // ==========================================================
   // event pulses
   // registered so events never land on the block's sampling edge
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         eventPulse <= '0;
      end else begin
         eventPulse <= fire;
      end
   end
endmodule // event_source

// >>> int_expansion_sva.sv
/*
 * checker for the two-level interrupt path, bound to int_expansion.
 * assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/1ns
`include "int_expansion_consts.vh"

module int_expansion_sva (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // inputs watched
   input wire logic [`NUM_SRC-1:0] eventClear,
   input wire logic [`DATA_W-1:0] dataAddr,
   input wire logic dataRd,
   // outputs watched
   input wire logic [`NUM_SRC-1:0] eventFlag_r,
   input wire logic [`NUM_SRC-1:0] peripheralRequest_r,
   input wire logic [`NUM_SRC-1:0] peripheralAck_r,
   input wire logic [`NUM_LVL-1:0] cpuLevelRequest_b,
   input wire logic globalMask_r,
   input wire logic intAck_r,
   input wire logic [`DATA_W-1:0] programAddr_r,
   input wire logic [`DATA_W-1:0] vector_r,
   input wire logic [`DATA_W-1:0] rdData_r
);
   // ==========================================================
   // helper: vector expected from the acknowledged source
   logic [15:0] ackVec;
   always_comb begin
      ackVec = 16'h0000;
      for (int i = 0; i < `NUM_SRC; i++) begin
         if (peripheralAck_r[i]) begin
            ackVec = 16'(i + 1);
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // sequences
   sequence ackThen;
      intAck_r ##1 1'h1;
   endsequence
   sequence quietFour;
      (!intAck_r) [*4];
   endsequence

   // ==========================================================
   // assertions
   for (genvar k = 0; k < `NUM_LVL; k++) begin : g_lvl
      a_pulse_two_low: assert property ($fell(cpuLevelRequest_b[k]) |=>
         !cpuLevelRequest_b[k] ##1 cpuLevelRequest_b[k])
         else $error("level pulse not two cycles low");
   end
   a_ack_one_cycle: assert property (intAck_r |=> !intAck_r)
      else $error("acknowledge longer than one cycle");
   a_ack_addr_level: assert property (intAck_r |-> !programAddr_r[0] &&
      programAddr_r >= 16'h0002 && programAddr_r <= 16'h000C)
      else $error("acknowledge address not a level vector");
   a_addr_idle_zero: assert property (!intAck_r |-> programAddr_r == 16'h0000)
      else $error("address driven outside acknowledge");
   a_ack_sets_mask: assert property (intAck_r |-> globalMask_r)
      else $error("acknowledge with global mask clear");
   a_core_latency_min: assert property ($rose(globalMask_r) |->
      quietFour ##[1:990] intAck_r)
      else $error("core latency out of range");
   a_pack_after_ack: assert property (peripheralAck_r != '0 |->
      $past(intAck_r) && $onehot(peripheralAck_r))
      else $error("peripheral ack not one-hot after acknowledge");
   a_vector_load: assert property (ackThen |-> vector_r == ackVec)
      else $error("vector register wrong after acknowledge");
   a_ack_clears_req: assert property (peripheralAck_r != '0 |=>
      (peripheralRequest_r & $past(peripheralAck_r)) == '0)
      else $error("acknowledged request still set");
   a_event_flag_kept: assert property (peripheralAck_r != '0 &&
      (eventClear & peripheralAck_r) == '0 |=>
      (eventFlag_r & $past(peripheralAck_r)) != '0)
      else $error("event flag cleared by acknowledge");
   a_rd_reserved_zero: assert property ($past(dataRd) &&
      $past(dataAddr) == `ADDR_LEVEL_FLAGS |-> rdData_r[15:6] == 10'h000)
      else $error("reserved flag bits read nonzero");
endmodule // int_expansion_sva

bind int_expansion int_expansion_sva u_sva (.clk, .rst_b, .eventClear,
   .dataAddr, .dataRd, .eventFlag_r, .peripheralRequest_r, .peripheralAck_r,
   .cpuLevelRequest_b, .globalMask_r, .intAck_r, .programAddr_r, .vector_r,
   .rdData_r);

// >>> two_level_interrupt_flag_mask_tb.sv
/*
 * bench for int_expansion: register, event and interrupt scenarios.
 * assumes event_source as the peripheral side and the bound checker.
 */
`timescale 1ns/1ns
`include "int_expansion_consts.vh"

module two_level_interrupt_flag_mask_tb;
   logic clk, rst_b, dataWr, dataRd, interruptible, globalMaskClear;
   logic swIntReq, globalMask_r, intAck_r;
   logic [2:0] swIntLevel;
   logic [5:0] cpuLevelRequest_b;
   logic [15:0] dataAddr, dataWrData, programAddr_r, vector_r, rdData_r;
   logic [30:0] fire, eventPulse, eventEnable, eventFlag_r;
   logic [30:0] peripheralRequest_r, peripheralAck_r, eventClear;
   int miscompares = 0, total_checks = 0, lowCnt, ackSeen = 0;

   event_source u_src (.clk, .rst_b, .fire, .eventPulse);
   int_expansion u_dut (.clk, .rst_b, .eventPulse, .eventClear,
      .eventEnable, .dataAddr, .dataWrData, .dataWr, .dataRd, .interruptible,
      .globalMaskClear, .swIntReq, .swIntLevel, .eventFlag_r,
      .peripheralRequest_r, .peripheralAck_r, .cpuLevelRequest_b,
      .globalMask_r, .intAck_r, .programAddr_r, .vector_r, .rdData_r);

   // ==========================================================
   // clock and acknowledge monitor
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (intAck_r === 1'h1) ackSeen++;
   end

   // ==========================================================
   // tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic doReset();
      rst_b <= 1'h0;
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
   endtask
   task automatic wr(input logic [15:0] a, d);
      @(posedge clk);
      dataAddr <= a;
      dataWrData <= d;
      dataWr <= 1'h1;
      @(posedge clk);
      dataWr <= 1'h0;
   endtask
   task automatic rd(input logic [15:0] a, exp);
      @(posedge clk);
      dataAddr <= a;
      dataRd <= 1'h1;
      @(posedge clk);
      dataRd <= 1'h0;
      #1 chk(rdData_r, exp, "register read");
   endtask
   task automatic gclr();
      @(posedge clk);
      globalMaskClear <= 1'h1;
      @(posedge clk);
      globalMaskClear <= 1'h0;
   endtask
   task automatic swInt(input logic [2:0] lvl);
      @(posedge clk);
      swIntLevel <= lvl;
      swIntReq <= 1'h1;
      @(posedge clk);
      swIntReq <= 1'h0;
   endtask
   task automatic fireEv(input logic [30:0] m);
      @(posedge clk);
      fire <= m;
      @(posedge clk);
      fire <= 31'h00000000;
      repeat (8) @(posedge clk);
   endtask
   // wait for acknowledge, then check address, ack, vector, event flag
   task automatic takeChk(input logic [15:0] addr, vec, input logic [30:0] ack);
      int n;
      n = 0;
      #1;
      while (intAck_r !== 1'h1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 200) begin
         miscompares++;
         end_of_test();
      end
      chk(programAddr_r, addr, "acknowledge address");
      @(posedge clk);
      #1 chk(peripheralAck_r, ack, "peripheral ack");
      chk(vector_r, vec, "vector");
      chk(eventFlag_r & ack, ack, "event flag kept");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      rst_b = 1'h0;
      fire = 31'h00000000;
      eventClear = 31'h00000000;
      eventEnable = 31'h7FFEFFFF;
      dataAddr = 16'h0000;
      dataWrData = 16'h0000;
      dataWr = 1'h0;
      dataRd = 1'h0;
      interruptible = 1'h1;
      globalMaskClear = 1'h0;
      swIntReq = 1'h0;
      swIntLevel = 3'h1;
      doReset();
      rd(16'h0006, 16'h0000);
      rd(16'h701E, 16'h0000);
      rd(16'h0100, 16'h0000);
      wr(16'h0004, 16'h003F);
      doReset();
      rd(16'h0004, 16'h003F);
      $display("test reset done");
      // disabled event, then late enable, all levels masked
      wr(16'h0004, 16'h0000);
      gclr();
      fireEv(31'h00010000);
      #1 chk(eventFlag_r[16], 1'h1, "flag held");
      chk(peripheralRequest_r[16], 1'h0, "request while disabled");
      @(posedge clk);
      eventEnable[16] <= 1'h1;
      lowCnt = 0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         if (i == 0) chk(peripheralRequest_r[16], 1'h1, "request");
         if (cpuLevelRequest_b[2] === 1'h0) lowCnt++;
      end
      chk(lowCnt, 2, "level pulse length");
      rd(16'h0006, 16'h0004);
      chk(ackSeen, 0, "masked level taken");
      wr(16'h0006, 16'h0000);
      rd(16'h0006, 16'h0004);
      wr(16'h0006, 16'h0004);
      rd(16'h0006, 16'h0000);
      $display("test flags done");
      // software entry: level three, then level one with flag set
      swInt(3'h3);
      takeChk(16'h0006, 16'h0011, 31'h00010000);
      rd(16'h701E, 16'h0011);
      gclr();
      fireEv(31'h00000001);
      swInt(3'h1);
      takeChk(16'h0002, 16'h0001, 31'h00000001);
      rd(16'h0006, 16'h0001);
      wr(16'h0006, 16'h0001);
      gclr();
      $display("test software entry done");
      // stalled core, higher level arrives during the stall
      interruptible <= 1'h0;
      wr(16'h0004, 16'h003F);
      fireEv(31'h00800000);
      fireEv(31'h00000600);
      chk(ackSeen, 2, "taken while stalled");
      @(posedge clk);
      interruptible <= 1'h1;
      takeChk(16'h0004, 16'h000A, 31'h00000200);
      chk(globalMask_r, 1'h1, "global mask set");
      repeat (6) @(posedge clk);
      rd(16'h0006, 16'h0012);
      rd(16'h701E, 16'h000A);
      gclr();
      takeChk(16'h0004, 16'h000B, 31'h00000400);
      repeat (2) @(posedge clk);
      rd(16'h0006, 16'h0010);
      gclr();
      takeChk(16'h000A, 16'h0018, 31'h00800000);
      rd(16'h0006, 16'h0000);
      wr(16'h701E, 16'hFFFF);
      rd(16'h701E, 16'h0018);
      @(posedge clk);
      eventClear <= 31'h00800000;
      @(posedge clk);
      eventClear <= 31'h00000000;
      #1 chk(eventFlag_r[23], 1'h0, "flag cleared by software");
      $display("test priority done");
      end_of_test();
   end
endmodule // two_level_interrupt_flag_mask_tb
